// *** inc/spc_defines.vh ***
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// Selection bit positions in the system I/O select word
`define SPC_SEL_TDI        4
`define SPC_SEL_TDO        5
`define SPC_SEL_TMS        6
`define SPC_SEL_TCK        7
`define SPC_SEL_USB_MINUS  10
`define SPC_SEL_USB_PLUS   11
`define SPC_SEL_WIPE       12
`define SPC_SEL_W          13

// Reset value: every shared pin in its system function (bit clear = system)
`define SPC_SEL_RST        13'h0000

// Wipe windows, in milliseconds
`define SPC_WIPE_IGNORE_MS 100
`define SPC_WIPE_ERASE_MS  220

// Serial wire switch sequence (16 bits, LSB first), arbitrary-form default
`define SPC_SWD_SEQ        16'hE79E
`define SPC_SWD_SEQ_W      16

// Outgoing reset minimum pulse, in clock cycles
`define SPC_RST_PULSE_CYC  16'h0040

// Debug port modes
`define SPC_DP_JTAG        1'b0
`define SPC_DP_SWD         1'b1

`endif

// *** src/spc_system_pin_config.v ***
`timescale 1ns/1ps
// Overview of operation
// - Shared pins start in system function
// - One select bit per shared pin
// - Bits 7..4 select debug pins or GPIO
// - Pad settings apply in either mode
// - JTAG first; sequence switches to serial wire
// - Trace output only while serial wire active
// - Scan select high routes JTAG to scan
// - Test input selects test or fast programming
// - Reset pin bidirectional, external low resets
// - Pin reset spares the backup region
// - Incoming low seen at a clock edge accepted; outgoing pulse has minimum
// - Reset pin input by default
// - Wipe erases flash to all ones
// - Wipe input debounced by slow clock
// - Wipe high under 100 ms ignored
// - Wipe high over 220 ms erases
// - Wipe pin as output never erases
`include "spc_defines.vh"

module spc_system_pin_config #(
    parameter SLOW_HZ        = 32768,   // Slow clock rate feeding the debounce enable
    parameter DEBOUNCE_TICKS = 4        // Slow ticks the wipe level must be stable
) (
    input  wire        ref_clk_i,        // Master clock, 100 MHz
    input  wire        rst_n_i,          // Asynchronous reset, active low
    input  wire        slow_tick_i,      // One-cycle enable at the slow clock rate
    // Software selection word: bit set = general-purpose line
    input  wire [12:0] sel_wr_data_i,    // New selection value
    input  wire        sel_wr_en_i,      // Write strobe for the selection word
    output reg  [12:0] sel_o,            // Current selection word
    // Pad settings, passed to the pads in any mode
    input  wire [12:0] pad_pullup_i,     // Pull-up enables
    input  wire [12:0] pad_schmitt_i,    // Input trigger enables
    input  wire [12:0] pad_filter_i,     // Glitch/debounce filter enables
    output reg  [12:0] pad_pullup_o,     // Pull-up to pads
    output reg  [12:0] pad_schmitt_o,    // Trigger to pads
    output reg  [12:0] pad_filter_o,     // Filter to pads
    // Debug pins
    input  wire        tck_pin_i,        // Test clock / serial wire clock pin
    input  wire        tms_pin_i,        // Mode select / serial wire data pin
    input  wire        tdi_pin_i,        // Test data in pin
    input  wire        dbg_tdo_i,        // Test data out from the debug logic
    input  wire        trace_data_i,     // Trace stream from the trace unit
    input  wire        trace_en_i,       // Trace unit wants the pin
    output reg         tdo_pin_o,        // Pin value for test data out
    output reg         tdo_pin_oe_o,     // Pin enable for test data out
    output reg         dbg_tck_o,        // Clock to debug port (0 when GPIO)
    output reg         dbg_tms_o,        // Mode select to debug port
    output reg         dbg_tdi_o,        // Data in to debug port
    output reg         dp_mode_o,        // 0 JTAG, 1 serial wire
    output reg         async_trace_out_o,// Trace driven on shared pin
    // GPIO side of shared debug pins
    input  wire [3:0]  gpio_out_i,       // GPIO data for pins TDI..TCK
    input  wire [3:0]  gpio_oe_i,        // GPIO enables for pins TDI..TCK
    output reg  [3:0]  gpio_in_o,        // Pin levels back to GPIO
    // Test strap pins
    input  wire        boundary_scan_select_i, // High routes JTAG to scan chain
    input  wire        test_mode_input_i,      // High enters test/programming
    input  wire        fast_prog_req_i,        // With test input: fast programming
    output reg         scan_route_o,     // JTAG goes to boundary scan
    output reg         mfg_test_o,       // Boundary-scan manufacturing test
    output reg         fast_prog_o,      // Fast flash programming mode
    // Reset pin
    input  wire        external_reset_pin_i,   // Pin level
    input  wire        rstc_req_i,       // Reset controller asks for outgoing reset
    output reg         external_reset_pin_o,   // Pin output value
    output reg         external_reset_pin_oe_o,// Pin drive enable
    output reg         core_periph_rst_o,// Reset core and peripherals
    output reg         backup_rst_o,     // Reset backup region (never from pin)
    // Wipe pin
    input  wire        portb_line_twelve_i,    // Wipe pin level
    input  wire        wipe_gpio_oe_i,   // GPIO drives the wipe pin
    input  wire        erase_done_i,     // Flash reports erase complete
    output reg         flash_erase_o,    // Full flash and NVM erase, one-cycle pulse
    output reg         wipe_busy_o       // Erase in progress
);

    ////////////////////////////////////////////////////////////////////////////
    // Derived constants

    localparam [31:0] IGN_TICKS = (`SPC_WIPE_IGNORE_MS * SLOW_HZ) / 1000;
    localparam [31:0] ERA_TICKS = (`SPC_WIPE_ERASE_MS * SLOW_HZ + 999) / 1000;

    // Bit in the selection word
    function sel_bit;
        input [12:0] w;
        input integer idx;
        begin
            sel_bit = w[idx];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Selection word

    reg [12:0] sel_r;                    // Bit set = GPIO

    // Reset puts every pin in system function
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_r <= `SPC_SEL_RST;
        end else if (sel_wr_en_i) begin
            sel_r <= sel_wr_data_i;
        end
    end

    // Registered view of the selection and pad settings
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_o         <= 13'h0000;
            pad_pullup_o  <= 13'h0000;
            pad_schmitt_o <= 13'h0000;
            pad_filter_o  <= 13'h0000;
        end else begin
            sel_o         <= sel_r;
            // Pad controls do not look at the selection
            pad_pullup_o  <= pad_pullup_i;
            pad_schmitt_o <= pad_schmitt_i;
            pad_filter_o  <= pad_filter_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug port mode: shift in TMS on TCK rising edges

    reg                       tck_d_r;   // Previous TCK sample
    reg [`SPC_SWD_SEQ_W-1:0]  seq_r;     // Recent TMS bits
    wire tck_rise = tck_pin_i & ~tck_d_r;
    wire dbg_pins = ~sel_bit(sel_r, `SPC_SEL_TCK) & ~sel_bit(sel_r, `SPC_SEL_TMS);

    // Host must send the switch sequence; JTAG until then
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tck_d_r   <= 1'b0;
            seq_r     <= {`SPC_SWD_SEQ_W{1'b0}};
            dp_mode_o <= `SPC_DP_JTAG;
        end else begin
            tck_d_r <= tck_pin_i;
            if (tck_rise && dbg_pins) begin
                seq_r <= {tms_pin_i, seq_r[`SPC_SWD_SEQ_W-1:1]};
                if ({tms_pin_i, seq_r[`SPC_SWD_SEQ_W-1:1]} == `SPC_SWD_SEQ) begin
                    dp_mode_o <= `SPC_DP_SWD;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug pin multiplexing

    // Route each debug pin to the port or to GPIO
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dbg_tck_o         <= 1'b0;
            dbg_tms_o         <= 1'b0;
            dbg_tdi_o         <= 1'b0;
            tdo_pin_o         <= 1'b0;
            tdo_pin_oe_o      <= 1'b0;
            async_trace_out_o <= 1'b0;
            gpio_in_o         <= 4'h0;
        end else begin
            dbg_tck_o <= sel_bit(sel_r, `SPC_SEL_TCK) ? 1'b0 : tck_pin_i;
            dbg_tms_o <= sel_bit(sel_r, `SPC_SEL_TMS) ? 1'b0 : tms_pin_i;
            dbg_tdi_o <= sel_bit(sel_r, `SPC_SEL_TDI) ? 1'b0 : tdi_pin_i;
            gpio_in_o <= {tck_pin_i, tms_pin_i, 1'b0, tdi_pin_i};
            if (sel_bit(sel_r, `SPC_SEL_TDO)) begin
                // GPIO owns the data out pin
                tdo_pin_o         <= gpio_out_i[1];
                tdo_pin_oe_o      <= gpio_oe_i[1];
                async_trace_out_o <= 1'b0;
            end else if (dp_mode_o == `SPC_DP_SWD) begin
                // Trace only with serial wire; JTAG never loses its TDO
                tdo_pin_o         <= trace_data_i;
                tdo_pin_oe_o      <= trace_en_i;
                async_trace_out_o <= trace_en_i;
            end else begin
                tdo_pin_o         <= dbg_tdo_i;
                tdo_pin_oe_o      <= 1'b1;
                async_trace_out_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test straps, sampled on every clock after reset release

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_route_o <= 1'b0;
            mfg_test_o   <= 1'b0;
            fast_prog_o  <= 1'b0;
        end else begin
            scan_route_o <= boundary_scan_select_i;
            mfg_test_o   <= test_mode_input_i & ~fast_prog_req_i;
            fast_prog_o  <= test_mode_input_i & fast_prog_req_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset pin: drive low for a minimum pulse on request, else input

    reg [15:0] rst_cnt_r;                // Outgoing pulse counter

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_cnt_r               <= 16'h0000;
            external_reset_pin_o    <= 1'b0;
            external_reset_pin_oe_o <= 1'b0;
            core_periph_rst_o       <= 1'b0;
            backup_rst_o            <= 1'b0;
        end else begin
            if (rstc_req_i) begin
                rst_cnt_r <= `SPC_RST_PULSE_CYC;
            end else if (rst_cnt_r != 16'h0000) begin
                rst_cnt_r <= rst_cnt_r - 16'h0001;
            end
            external_reset_pin_o    <= 1'b0;
            // Enabled only while the pulse lasts
            external_reset_pin_oe_o <= rstc_req_i | (rst_cnt_r > 16'h0001);
            // Pin sampled each clock; a low seen at a rising edge resets
            core_periph_rst_o <= ~external_reset_pin_i;
            backup_rst_o      <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wipe detector

    reg [3:0]  deb_cnt_r;                // Debounce stability count
    reg        deb_lvl_r;                // Debounced level
    reg [31:0] dur_r;                    // High duration in slow ticks
    reg        fired_r;                  // Erase issued for this assertion

    // GPIO selection or GPIO driving hides the pin from the detector
    wire wipe_raw = portb_line_twelve_i & ~sel_bit(sel_r, `SPC_SEL_WIPE)
                    & ~wipe_gpio_oe_i;

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deb_cnt_r     <= 4'h0;
            deb_lvl_r     <= 1'b0;
            dur_r         <= 32'h0000_0000;
            fired_r       <= 1'b0;
            flash_erase_o <= 1'b0;
            wipe_busy_o   <= 1'b0;
        end else begin
            flash_erase_o <= 1'b0;
            if (erase_done_i) begin
                wipe_busy_o <= 1'b0;
            end
            if (slow_tick_i) begin
                // Level must hold steady for several slow ticks
                if (wipe_raw == deb_lvl_r) begin
                    deb_cnt_r <= 4'h0;
                end else if (deb_cnt_r == DEBOUNCE_TICKS[3:0] - 4'h1) begin
                    deb_cnt_r <= 4'h0;
                    deb_lvl_r <= wipe_raw;
                end else begin
                    deb_cnt_r <= deb_cnt_r + 4'h1;
                end
                if (!deb_lvl_r) begin
                    dur_r   <= 32'h0000_0000;
                    fired_r <= 1'b0;
                end else if (!fired_r) begin
                    dur_r <= dur_r + 32'h0000_0001;
                    // Below the ignore window nothing can fire
                    if (dur_r >= ERA_TICKS && dur_r >= IGN_TICKS) begin
                        fired_r       <= 1'b1;
                        flash_erase_o <= 1'b1;
                        wipe_busy_o   <= 1'b1;
                    end
                end
            end
        end
    end

endmodule // spc_system_pin_config

// *** tb/spc_chk_checker.sv ***
`timescale 1ns/1ps
module spc_chk (
    input wire        ref_clk_i,
    input wire        rst_n_i,
    input wire        sel_wr_en_i,
    input wire [12:0] sel_wr_data_i,
    input wire [12:0] sel_o,
    input wire        dbg_tck_o,
    input wire        dp_mode_o,
    input wire        async_trace_out_o,
    input wire        boundary_scan_select_i,
    input wire        scan_route_o,
    input wire        rstc_req_i,
    input wire        external_reset_pin_i,
    input wire        external_reset_pin_o,
    input wire        external_reset_pin_oe_o,
    input wire        core_periph_rst_o,
    input wire        backup_rst_o,
    input wire        flash_erase_o
);
    // One clock domain, so one clocking and one disable serve all
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////
    property p_sel; sel_wr_en_i ##1 !sel_wr_en_i |-> ##1 sel_o == $past(sel_wr_data_i, 2); endproperty
    a_sel: assert property (p_sel) else $error("selection word not taken");
    property p_dbg; sel_o[7] && $past(sel_o[7]) |-> !dbg_tck_o; endproperty
    a_dbg: assert property (p_dbg) else $error("debug clock leaks in GPIO mode");
    property p_trc; async_trace_out_o |-> dp_mode_o; endproperty
    a_trc: assert property (p_trc) else $error("trace driven while JTAG active");
    property p_scan; $rose(boundary_scan_select_i) |-> ##[1:2] scan_route_o; endproperty
    a_scan: assert property (p_scan) else $error("scan route not taken");
    property p_pin; !external_reset_pin_i |=> core_periph_rst_o && !backup_rst_o; endproperty
    a_pin: assert property (p_pin) else $error("pin reset wrong");
    property p_oe; rstc_req_i |=> external_reset_pin_oe_o && !external_reset_pin_o; endproperty
    a_oe: assert property (p_oe) else $error("outgoing reset not driven low");
    property p_oe_src; $rose(external_reset_pin_oe_o) |-> $past(rstc_req_i); endproperty
    a_oe_src: assert property (p_oe_src) else $error("reset pin driven unasked");
    property p_len; $fell(external_reset_pin_oe_o) |-> $past(external_reset_pin_oe_o, 64); endproperty
    a_len: assert property (p_len) else $error("outgoing reset too short");
    property p_ers; flash_erase_o |=> !flash_erase_o; endproperty
    a_ers: assert property (p_ers) else $error("erase pulse too long");
    property p_gp; sel_o[12] && $past(sel_o[12], 8) |-> !flash_erase_o; endproperty
    a_gp: assert property (p_gp) else $error("erase from GPIO wipe pin");
endmodule // spc_chk
bind spc_system_pin_config spc_chk u_spc_chk (.ref_clk_i, .rst_n_i, .sel_wr_en_i,
    .sel_wr_data_i, .sel_o, .dbg_tck_o, .dp_mode_o, .async_trace_out_o, .boundary_scan_select_i,
    .scan_route_o, .rstc_req_i, .external_reset_pin_i, .external_reset_pin_o,
    .external_reset_pin_oe_o, .core_periph_rst_o, .backup_rst_o, .flash_erase_o);

// *** tb/spc_board.sv ***
`timescale 1ns/1ps
module spc_board (
    input  wire clk_i,     // Master clock, for pacing only
    input  wire rst_oe_i,  // Device drives the reset line
    input  wire rst_val_i, // Value the device drives
    output reg  tck_o,     // Probe clock, idles low between frames
    output reg  tms_o,     // Probe data
    output reg  wipe_o,    // Wipe line, low from startup
    output wire rst_pin_o  // Reset line level
);
    reg ext_low;           // Board pushbutton pulls the line low
    // Pull-up unless someone pulls low
    assign rst_pin_o = !(ext_low || (rst_oe_i && !rst_val_i));
    initial begin
        {tck_o, tms_o, wipe_o, ext_low} = 4'h0;
    end
    // Switch sequence, LSB first, data set well before the clock rises
    task send_switch(input [15:0] seq);
        integer n;
        begin
            for (n = 0; n < 16; n = n + 1) begin
                @(posedge clk_i);
                #1 tms_o = seq[n];
                @(posedge clk_i);
                #1 tck_o = 1'b1;
                @(posedge clk_i);
                #1 tck_o = 1'b0;
            end
            tms_o = ~tms_o; // Released line shows no stale value
        end
    endtask
    // Hold the wipe line high for a number of master cycles
    task wipe(input integer cyc);
        begin
            @(posedge clk_i);
            #1 wipe_o = 1'b1;
            repeat (cyc) @(posedge clk_i);
            #1 wipe_o = 1'b0;
        end
    endtask
endmodule // spc_board

// *** tb/system_pin_config_and_erase_tb.sv ***
`timescale 1ns/1ps
module system_pin_config_and_erase_tb;
    reg         ref_clk_i, rst_n_i, slow_tick_i, sel_wr_en_i, dbg_tdo_i, trace_data_i;
    reg         trace_en_i, tdi_pin_i, boundary_scan_select_i, test_mode_input_i;
    reg         fast_prog_req_i, rstc_req_i, wipe_gpio_oe_i, erase_done_i;
    reg  [12:0] sel_wr_data_i, pad_pullup_i, pad_schmitt_i, pad_filter_i, last_w, sel_prev;
    reg  [12:0] n_ers;
    reg  [3:0]  gpio_out_i, gpio_oe_i;
    reg  [1:0]  tc;
    wire [12:0] sel_o, pad_pullup_o, pad_schmitt_o, pad_filter_o;
    wire [3:0]  gpio_in_o;
    wire        tck_pin_i, tms_pin_i, portb_line_twelve_i, external_reset_pin_i;
    wire        tdo_pin_o, tdo_pin_oe_o, dbg_tck_o, dbg_tms_o, dbg_tdi_o, dp_mode_o;
    wire        async_trace_out_o, scan_route_o, mfg_test_o, fast_prog_o, external_reset_pin_o;
    wire        external_reset_pin_oe_o, core_periph_rst_o, backup_rst_o, flash_erase_o;
    wire        wipe_busy_o;
    integer     err_total, n_checks, seed, i, k;
    reg  [12:0] exp_q[$];   // Selection values still owed by the design
    ////////////////////////////////////////////////////////////////
    // Small SLOW_HZ keeps the wipe windows at 40 and 88 cycles
    spc_system_pin_config #(.SLOW_HZ(100), .DEBOUNCE_TICKS(4)) u_spc_system_pin_config (
        .ref_clk_i, .rst_n_i, .slow_tick_i, .sel_wr_data_i, .sel_wr_en_i, .sel_o,
        .pad_pullup_i, .pad_schmitt_i, .pad_filter_i, .pad_pullup_o, .pad_schmitt_o,
        .pad_filter_o, .tck_pin_i, .tms_pin_i, .tdi_pin_i, .dbg_tdo_i, .trace_data_i,
        .trace_en_i, .tdo_pin_o, .tdo_pin_oe_o, .dbg_tck_o, .dbg_tms_o, .dbg_tdi_o, .dp_mode_o,
        .async_trace_out_o, .gpio_out_i, .gpio_oe_i, .gpio_in_o, .boundary_scan_select_i,
        .test_mode_input_i, .fast_prog_req_i, .scan_route_o, .mfg_test_o, .fast_prog_o,
        .external_reset_pin_i, .rstc_req_i, .external_reset_pin_o, .external_reset_pin_oe_o,
        .core_periph_rst_o, .backup_rst_o, .portb_line_twelve_i, .wipe_gpio_oe_i,
        .erase_done_i, .flash_erase_o, .wipe_busy_o);
    spc_board u_spc_board (.clk_i(ref_clk_i), .rst_oe_i(external_reset_pin_oe_o),
        .rst_val_i(external_reset_pin_o), .tck_o(tck_pin_i), .tms_o(tms_pin_i),
        .wipe_o(portb_line_twelve_i), .rst_pin_o(external_reset_pin_i));
    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Slow tick every fourth cycle, far faster than real but same shape
    always @(posedge ref_clk_i) begin
        tc <= tc + 2'h1;
        slow_tick_i <= #1 (tc == 2'h3);
    end
    // Monitor: each change of the selection word settles the oldest note
    always @(posedge ref_clk_i) begin
        if (rst_n_i && sel_o !== sel_prev) begin
            if (exp_q.size() == 0) check("sel_extra", sel_o, sel_prev);
            else check("sel", sel_o, exp_q.pop_front());
        end
        sel_prev <= sel_o;
        if (flash_erase_o) n_ers <= n_ers + 13'h0001;
    end
    task check(input string name, input [12:0] got, input [12:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // Write strobe is left high so calls may run back to back
    task wsel(input [12:0] v);
        begin
            if (v !== last_w) exp_q.push_back(v);
            last_w = v;
            sel_wr_data_i = v;
            sel_wr_en_i = 1'b1;
            @(posedge ref_clk_i);
            #1;
        end
    endtask
    // Wipe of a given length; erases counted by the monitor
    task wipe_case(input integer hi, input [12:0] exp);
        begin
            n_ers = 13'h0000;
            u_spc_board.wipe(hi);
            for (i = 0; i < 100 && n_ers == 0; i = i + 1) @(posedge ref_clk_i);
            #1 check("erases", n_ers, exp);
            check("busy", wipe_busy_o, exp);
            erase_done_i = 1'b1;
            @(posedge ref_clk_i);
            #1 erase_done_i = 1'b0;
        end
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total = err_total + 1;
        conclude;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n_i, sel_wr_en_i, dbg_tdo_i, trace_data_i, trace_en_i, tdi_pin_i} = 6'h00;
        {boundary_scan_select_i, test_mode_input_i, fast_prog_req_i, rstc_req_i} = 4'h0;
        {wipe_gpio_oe_i, erase_done_i, slow_tick_i, tc, gpio_out_i, gpio_oe_i} = 13'h0000;
        {sel_wr_data_i, pad_pullup_i, pad_schmitt_i, pad_filter_i} = 52'h0;
        {last_w, sel_prev, n_ers} = 39'h0;
        {err_total, n_checks, seed} = {32'h0000_0000, 32'h0000_0000, 32'h0000_5D4F};
        repeat (8) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        @(posedge ref_clk_i);
        #1 check("sel_reset", sel_o, 13'h0000);
        check("dp_reset", dp_mode_o, 13'h0000);
        check("oe_reset", external_reset_pin_oe_o, 13'h0000);
        $display("reset test done");
        for (k = 0; k < 6; k = k + 1) begin
            {pad_pullup_i, pad_filter_i, pad_schmitt_i} = {$random(seed), $random(seed)};
            {gpio_out_i, gpio_oe_i} = $random(seed);
            wsel($random(seed));
        end
        wsel(13'h0080);
        sel_wr_en_i = 1'b0;
        // Clock pin is GPIO here: its rise must not shift, other pins still pass
        {u_spc_board.tck_o, u_spc_board.tms_o, tdi_pin_i} = 3'h7;
        repeat (3) @(posedge ref_clk_i);
        #1 check("pad_pullup", pad_pullup_o, pad_pullup_i);
        check("pad_schmitt", pad_schmitt_o, pad_schmitt_i);
        check("pad_filter", pad_filter_o, pad_filter_i);
        check("dbg_tck", dbg_tck_o, 13'h0000);
        check("gpio_pins", gpio_in_o, 13'h000D);
        check("dbg_tms_tdi", {dbg_tms_o, dbg_tdi_o}, 13'h0003);
        {u_spc_board.tck_o, u_spc_board.tms_o} = 2'h0;
        wsel(13'h0000);
        sel_wr_en_i = 1'b0;
        {trace_en_i, trace_data_i} = 2'b11;
        u_spc_board.send_switch(16'h1234);
        repeat (3) @(posedge ref_clk_i);
        #1 check("dp_wrong", dp_mode_o, 13'h0000);
        check("trace_jtag", async_trace_out_o, 13'h0000);
        check("tdo_jtag", {tdo_pin_oe_o, tdo_pin_o}, 13'h0002);
        u_spc_board.send_switch(16'hE79E);
        repeat (3) @(posedge ref_clk_i);
        #1 check("dp_swd", dp_mode_o, 13'h0001);
        check("trace_pin", {tdo_pin_oe_o, tdo_pin_o}, 13'h0003);
        $display("debug port test done");
        for (k = 0; k < 8; k = k + 1) begin
            {boundary_scan_select_i, test_mode_input_i, fast_prog_req_i} = k[2:0];
            repeat (3) @(posedge ref_clk_i);
            #1 check("straps", {scan_route_o, mfg_test_o, fast_prog_o},
                {boundary_scan_select_i, test_mode_input_i & ~fast_prog_req_i,
                 test_mode_input_i & fast_prog_req_i});
        end
        rstc_req_i = 1'b1;
        @(posedge ref_clk_i);
        #1 rstc_req_i = 1'b0;
        k = 0;
        repeat (100) @(posedge ref_clk_i) k = k + external_reset_pin_oe_o;
        #1 check("rst_len", (k >= 64 && k < 100), 13'h0001);
        u_spc_board.ext_low = 1'b1;
        @(posedge ref_clk_i);
        #1 u_spc_board.ext_low = 1'b0;
        check("pin_reset", {backup_rst_o, core_periph_rst_o}, 13'h0001);
        $display("reset pin test done");
        wipe_case(32, 13'h0000);
        u_spc_board.wipe(80);
        repeat (40) @(posedge ref_clk_i);
        wipe_case(80, 13'h0000);
        wsel(13'h1000);
        sel_wr_en_i = 1'b0;
        wipe_case(200, 13'h0000);
        // Mid-run reset: every pin back to system function, port back to JTAG
        rst_n_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        last_w = 13'h0000;
        @(posedge ref_clk_i);
        #1 check("sel_rerun", sel_o, 13'h0000);
        check("dp_rerun", dp_mode_o, 13'h0000);
        wsel(13'h0000);
        sel_wr_en_i = 1'b0;
        // GPIO driving the wipe line must not erase either
        wipe_gpio_oe_i = 1'b1;
        wipe_case(200, 13'h0000);
        wipe_gpio_oe_i = 1'b0;
        wipe_case(200, 13'h0001);
        $display("wipe test done");
        check("queue_left", exp_q.size(), 13'h0000);
        conclude;
    end
endmodule // system_pin_config_and_erase_tb
